// *** design/bocd_defines.svh ***
// register map, field positions, reset values and codes for the bank output config block
`ifndef BOCD_DEFINES_SVH
`define BOCD_DEFINES_SVH

// ****************************************
// register offsets
// ****************************************
`define BOCD_ADDR_TERM_B 4'h6
`define BOCD_ADDR_MODE_HI 4'h7
`define BOCD_ADDR_MODE_LO 4'h8
`define BOCD_ADDR_PAIR_DIS 4'h9
`define BOCD_ADDR_RATIO_A_LO 4'hc
`define BOCD_ADDR_RATIO_B_LO 4'hd
`define BOCD_ADDR_RATIO_HI 4'he
`define BOCD_ADDR_SPARE 4'hf

// ****************************************
// field positions
// ****************************************
`define BOCD_TERM_BIT 4
`define BOCD_MODE_UPPER_LSB 3
`define BOCD_DIS_LSB 4
`define BOCD_RATIO_A_HI_BIT 0
`define BOCD_RATIO_B_HI_BIT 1

// ****************************************
// reset values and codes
// ****************************************
`define BOCD_MODE_HIZ 3'h0
`define BOCD_MODE_LVPECL 3'h1
`define BOCD_MODE_LVDS 3'h2
`define BOCD_MODE_RSVD_A 3'h3
`define BOCD_MODE_HCSL 3'h4
`define BOCD_MODE_CML400 3'h5
`define BOCD_MODE_CML800 3'h6
`define BOCD_MODE_RSVD_B 3'h7
`define BOCD_MODE_RESET `BOCD_MODE_LVDS
`define BOCD_TERM_RESET 1'h0
`define BOCD_DIS_RESET 1'h0
`define BOCD_RATIO_RESET 9'h000
`define BOCD_RATIO_MIN_DIV 9'h002
`define BOCD_NUM_PAIRS 4

`endif

// *** design/bocd_pkg.sv ***
// types shared by the bank output config block
package bocd_pkg;

  // one register port access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } bocd_reg_req_t;

  // per-pair configuration as stored
  typedef struct packed {
    logic [2:0] mode;
    logic dis;
  } bocd_pair_cfg_t;

  // per-pair driver state presented to the pad ring
  typedef struct packed {
    logic [2:0] mode;
    logic oe;
    logic powerdown;
    logic term_50;
  } bocd_pair_drv_t;

endpackage

// *** design/bocd_top.sv ***
// second-bank output configuration registers and both bank ratio dividers
//
// Contract
// [R1] drive-mode codes select pair driver, reset LVDS
// [R2] termination flag used only in HCSL mode
// [R3] per-pair disable bit powers pair down
// [R4] host syncs bank disable before re-enabling pairs
// [R5] reserved bits written zero, read undefined
// [R6] first ratio 00h/01h bypasses first divider
// [R7] first ratio 02h-1FFh divides by value
// [R8] second ratio 00h/01h bypasses second divider
// [R9] second ratio 02h-1FFh divides by value
// [R10] ratio fields 9-bit read/write, reset zero
// [R11] bank sync disable tristates all, glitch-free; code clears the enables at once in any clock phase
// [R12] host zeroes second ratio before divider powerdown
// [R13] odd ratio phases differ by one period
`timescale 1ns/1ps
`include "bocd_defines.svh"

// ****************************************
// ratio divider
// ****************************************
module bocd_ratio_divider (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // control
  input wire logic [8:0] ratio_i,
  input wire logic hold_i,
  // outputs
  output logic bypass_o,
  output logic div_clk_o
);
  logic [8:0] cnt;
  logic [8:0] next_cnt;
  logic [8:0] half;
  logic divide;

  assign divide = (ratio_i >= `BOCD_RATIO_MIN_DIV) && !hold_i;
  // high phase is the larger half, so odd ratios split n/2 rounded up and down
  assign half = 9'((10'(ratio_i) + 10'h001) >> 1); // [R13]

  always_comb begin
    if (!divide || (cnt >= ratio_i - 9'h001)) begin
      next_cnt = 9'h000;
    end else begin
      next_cnt = cnt + 9'h001;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt <= 9'h000;
    end else if (ce_i) begin
      cnt <= next_cnt; // [R7] [R9]
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_clk_o <= 1'b0;
      bypass_o <= 1'b1;
    end else if (ce_i) begin
      bypass_o <= !divide; // [R6] [R8]
      div_clk_o <= divide && (next_cnt < half); // [R13]
    end
  end
endmodule

// ****************************************
// top
// ****************************************
module bocd_top (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // register port from the serial interface
  input wire bocd_pkg::bocd_reg_req_t reg_req_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // bank controls held outside this block
  input wire logic second_bank_sync_disable_i,
  input wire logic second_bank_divider_powerdown_i,
  // first bank
  output logic first_bank_bypass_o,
  output logic first_bank_div_clk_o,
  // second bank
  output logic second_bank_bypass_o,
  output logic [3:0] second_bank_true_out_o,
  output logic [3:0] second_bank_comp_out_o,
  output bocd_pkg::bocd_pair_drv_t [3:0] second_bank_pair_drv_o
);
  bocd_pkg::bocd_pair_cfg_t [3:0] pair_cfg;
  logic term_50;
  logic [8:0] first_bank_ratio;
  logic [8:0] second_bank_ratio;
  logic [3:0] pair_on;
  logic [3:0] next_pair_on;
  logic [3:0] pair_oe;
  logic b_bypass;
  logic b_clk;
  logic safe_edge;

  // ****************************************
  // register writes
  // ****************************************
  // reserved bits are not stored, so they cost no flops
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      term_50 <= `BOCD_TERM_RESET; // [R2]
    end else if (ce_i && reg_req_i.wr && reg_req_i.addr == `BOCD_ADDR_TERM_B) begin
      term_50 <= reg_req_i.wdata[`BOCD_TERM_BIT]; // [R2] [R5]
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < `BOCD_NUM_PAIRS; i++) begin
        pair_cfg[i].mode <= `BOCD_MODE_RESET; // [R1]
        pair_cfg[i].dis <= `BOCD_DIS_RESET; // [R3]
      end
    end else if (ce_i && reg_req_i.wr) begin
      unique case (reg_req_i.addr)
        `BOCD_ADDR_MODE_HI: begin
          pair_cfg[3].mode <= reg_req_i.wdata[5:3]; // [R1]
          pair_cfg[2].mode <= reg_req_i.wdata[2:0]; // [R1]
        end
        `BOCD_ADDR_MODE_LO: begin
          pair_cfg[1].mode <= reg_req_i.wdata[5:3]; // [R1]
          pair_cfg[0].mode <= reg_req_i.wdata[2:0]; // [R1]
        end
        `BOCD_ADDR_PAIR_DIS: begin
          for (int i = 0; i < `BOCD_NUM_PAIRS; i++) begin
            pair_cfg[i].dis <= reg_req_i.wdata[`BOCD_DIS_LSB + i]; // [R3]
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      first_bank_ratio <= `BOCD_RATIO_RESET; // [R10]
      second_bank_ratio <= `BOCD_RATIO_RESET; // [R10]
    end else if (ce_i && reg_req_i.wr) begin
      unique case (reg_req_i.addr)
        `BOCD_ADDR_RATIO_A_LO: first_bank_ratio[7:0] <= reg_req_i.wdata; // [R10]
        `BOCD_ADDR_RATIO_B_LO: second_bank_ratio[7:0] <= reg_req_i.wdata; // [R10]
        `BOCD_ADDR_RATIO_HI: begin
          first_bank_ratio[8] <= reg_req_i.wdata[`BOCD_RATIO_A_HI_BIT]; // [R10]
          second_bank_ratio[8] <= reg_req_i.wdata[`BOCD_RATIO_B_HI_BIT]; // [R10]
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // register reads
  // ****************************************
  // reserved positions and unmapped offsets read as zero
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else if (ce_i) begin
      reg_rvalid_o <= reg_req_i.rd;
      if (reg_req_i.rd) begin
        unique case (reg_req_i.addr)
          `BOCD_ADDR_TERM_B: reg_rdata_o <= {3'h0, term_50, 4'h0}; // [R5]
          `BOCD_ADDR_MODE_HI: reg_rdata_o <= {2'h0, pair_cfg[3].mode, pair_cfg[2].mode};
          `BOCD_ADDR_MODE_LO: reg_rdata_o <= {2'h0, pair_cfg[1].mode, pair_cfg[0].mode};
          `BOCD_ADDR_PAIR_DIS: begin
            reg_rdata_o <= {pair_cfg[3].dis, pair_cfg[2].dis, pair_cfg[1].dis, pair_cfg[0].dis, 4'h0};
          end
          `BOCD_ADDR_RATIO_A_LO: reg_rdata_o <= first_bank_ratio[7:0]; // [R10]
          `BOCD_ADDR_RATIO_B_LO: reg_rdata_o <= second_bank_ratio[7:0]; // [R10]
          `BOCD_ADDR_RATIO_HI: reg_rdata_o <= {6'h00, second_bank_ratio[8], first_bank_ratio[8]};
          default: reg_rdata_o <= 8'h00;
        endcase
      end
    end
  end

  // ****************************************
  // dividers
  // ****************************************
  bocd_ratio_divider u_div_a (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .ratio_i(first_bank_ratio),
    .hold_i(1'b0),
    .bypass_o(first_bank_bypass_o),
    .div_clk_o(first_bank_div_clk_o)
  );

  // powerdown with a nonzero ratio is host misuse; the divider is held and the bank falls to bypass
  bocd_ratio_divider u_div_b (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .ratio_i(second_bank_ratio),
    .hold_i(second_bank_divider_powerdown_i), // [R12]
    .bypass_o(b_bypass),
    .div_clk_o(b_clk)
  );

  // ****************************************
  // second bank drivers
  // ****************************************
  always_comb begin
    for (int i = 0; i < `BOCD_NUM_PAIRS; i++) begin
      next_pair_on[i] = !pair_cfg[i].dis && !second_bank_sync_disable_i; // [R3] [R11]
    end
  end

  // per-pair enables only change while the divided clock is low; sync disable clears them at once, in any phase, and can cut a high phase short
  assign safe_edge = b_bypass || !b_clk; // [R11] [R4]

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pair_on <= 4'h0;
    end else if (ce_i) begin
      if (second_bank_sync_disable_i) begin
        pair_on <= 4'h0; // [R11]
      end else if (safe_edge) begin
        pair_on <= next_pair_on; // [R11]
      end
    end
  end

  always_comb begin
    for (int i = 0; i < `BOCD_NUM_PAIRS; i++) begin
      // reserved codes drive nothing, same as high impedance
      pair_oe[i] = pair_on[i] && (pair_cfg[i].mode != `BOCD_MODE_HIZ) && // [R1]
                   (pair_cfg[i].mode != `BOCD_MODE_RSVD_A) && (pair_cfg[i].mode != `BOCD_MODE_RSVD_B);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      second_bank_bypass_o <= 1'b1;
      second_bank_true_out_o <= 4'h0;
      second_bank_comp_out_o <= 4'h0;
      for (int i = 0; i < `BOCD_NUM_PAIRS; i++) begin
        second_bank_pair_drv_o[i] <= '0;
      end
    end else if (ce_i) begin
      second_bank_bypass_o <= b_bypass; // [R8] [R9]
      for (int i = 0; i < `BOCD_NUM_PAIRS; i++) begin
        second_bank_true_out_o[i] <= pair_oe[i] && b_clk;
        second_bank_comp_out_o[i] <= pair_oe[i] && !b_clk;
        second_bank_pair_drv_o[i].mode <= pair_oe[i] ? pair_cfg[i].mode : `BOCD_MODE_HIZ; // [R1]
        second_bank_pair_drv_o[i].oe <= pair_oe[i]; // [R11]
        second_bank_pair_drv_o[i].powerdown <= pair_cfg[i].dis; // [R3]
        second_bank_pair_drv_o[i].term_50 <= term_50 && (pair_cfg[i].mode == `BOCD_MODE_HCSL); // [R2]
      end
    end
  end
endmodule

// *** bench/bocd_top_monitor.sv ***
// port assertions for the bank output config block
`timescale 1ns/1ps
module bocd_top_monitor (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // watched ports
  input wire bocd_pkg::bocd_reg_req_t reg_req_i,
  input wire logic reg_rvalid_o,
  input wire logic second_bank_sync_disable_i,
  input wire logic second_bank_divider_powerdown_i,
  input wire logic first_bank_bypass_o,
  input wire logic first_bank_div_clk_o,
  input wire logic second_bank_bypass_o,
  input wire logic [3:0] second_bank_true_out_o,
  input wire logic [3:0] second_bank_comp_out_o,
  input wire bocd_pkg::bocd_pair_drv_t [3:0] second_bank_pair_drv_o
);
  logic off_bad;
  logic term_bad;
  logic [3:0] oe;
  always_comb begin
    off_bad = 1'b0;
    term_bad = 1'b0;
    for (int i = 0; i < 4; i++) begin
      oe[i] = second_bank_pair_drv_o[i].oe;
      off_bad |= !oe[i] && (second_bank_pair_drv_o[i].mode != 3'h0 || second_bank_true_out_o[i] ||
                            second_bank_comp_out_o[i]);
      term_bad |= oe[i] && second_bank_pair_drv_o[i].term_50 && second_bank_pair_drv_o[i].mode != 3'h4;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  property p_read_answer; reg_req_i.rd && ce_i |=> reg_rvalid_o; endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  property p_no_stray; reg_rvalid_o |-> $past(reg_req_i.rd && ce_i); endproperty
  a_no_stray: assert property (p_no_stray) else $error("answer without read");
  property p_off_mode; !off_bad; endproperty
  a_off_mode: assert property (p_off_mode) else $error("pair off but driving");
  property p_term; !term_bad; endproperty
  a_term: assert property (p_term) else $error("termination outside hcsl");
  property p_sync_off; second_bank_sync_disable_i [*2] |=> oe == 4'h0 && second_bank_comp_out_o == 4'h0; endproperty
  a_sync_off: assert property (p_sync_off) else $error("bank not off under sync disable");
  property p_bypass_a; first_bank_bypass_o [*2] |-> !first_bank_div_clk_o; endproperty
  a_bypass_a: assert property (p_bypass_a) else $error("divider a toggles in bypass");
  // the bypass flag sits two flops behind the powerdown input
  property p_pd_bypass; second_bank_divider_powerdown_i [*2] |=> second_bank_bypass_o; endproperty
  a_pd_bypass: assert property (p_pd_bypass) else $error("divider b not bypassed");
  property p_dis_takes; $rose(second_bank_pair_drv_o[0].powerdown) |-> ##[0:600] !oe[0]; endproperty
  a_dis_takes: assert property (p_dis_takes) else $error("pair disable not taken");
  property p_freeze;
    !ce_i |=> $stable(first_bank_div_clk_o) && $stable(second_bank_true_out_o) && $stable(reg_rvalid_o);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with clock enable low");
  c_read: cover property (reg_req_i.rd ##1 reg_rvalid_o);
  c_sync: cover property (second_bank_sync_disable_i [*3]);
  c_div_a: cover property ($rose(first_bank_div_clk_o));
endmodule
bind bocd_top bocd_top_monitor i_mon (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ce_i(ce_i), .reg_req_i(reg_req_i),
  .reg_rvalid_o(reg_rvalid_o), .second_bank_sync_disable_i(second_bank_sync_disable_i),
  .second_bank_divider_powerdown_i(second_bank_divider_powerdown_i), .first_bank_bypass_o(first_bank_bypass_o),
  .first_bank_div_clk_o(first_bank_div_clk_o), .second_bank_bypass_o(second_bank_bypass_o),
  .second_bank_true_out_o(second_bank_true_out_o), .second_bank_comp_out_o(second_bank_comp_out_o),
  .second_bank_pair_drv_o(second_bank_pair_drv_o));

// *** bench/bocd_host_model.sv ***
// host model driving the register port
`timescale 1ns/1ps
module bocd_host_model (
  // clock
  input wire logic clk_sys_i,
  // register port
  output bocd_pkg::bocd_reg_req_t reg_req_o
);
  logic [7:0] exp_q[$];
  initial reg_req_o = '0;
  function automatic logic [7:0] used(input logic [3:0] a);
    case (a)
      4'h6: used = 8'h10;
      4'h7, 4'h8: used = 8'h3f;
      4'h9: used = 8'hf0;
      4'hc, 4'hd: used = 8'hff;
      4'he: used = 8'h03;
      default: used = 8'h00;
    endcase
  endfunction
  // one access a cycle, then an idle cycle so no field is driven twice at one edge
  task automatic cycle(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    reg_req_o <= '{w, !w, a, d & used(a)};
    @(negedge clk_sys_i);
    reg_req_o <= '0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    cycle(1'b1, a, d);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    cycle(1'b0, a, 8'h00);
  endtask
endmodule

// *** bench/tb.sv ***
// self-checking testbench for the bank output config block
`timescale 1ns/1ps
module tb;
  logic clk_sys_i;
  logic rstn_i = 1'b0;
  logic ce = 1'b1;
  logic sync_dis = 1'b0;
  logic div_pd = 1'b0;
  bocd_pkg::bocd_reg_req_t req;
  logic [7:0] rdata;
  logic rvalid, a_byp, a_clk, b_byp;
  logic [3:0] t_out, c_out;
  bocd_pkg::bocd_pair_drv_t [3:0] drv;
  int error_cnt = 0;
  int compares = 0;
  int cycles = 0;
  int seed = 7;
  int hi, lo;
  logic [8:0] ra = 9'h000;
  logic [8:0] rb = 9'h000;
  logic [3:0] addrs [8] = '{4'h6, 4'h7, 4'h8, 4'h9, 4'hc, 4'hd, 4'he, 4'hf};
  logic [7:0] rst [8] = '{8'h00, 8'h12, 8'h12, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [8:0] ratios [7] = '{9'h000, 9'h001, 9'h002, 9'h003, 9'h004, 9'h007, 9'h1ff};
  bocd_top i_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ce_i(ce), .reg_req_i(req), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .second_bank_sync_disable_i(sync_dis), .second_bank_divider_powerdown_i(div_pd),
    .first_bank_bypass_o(a_byp), .first_bank_div_clk_o(a_clk), .second_bank_bypass_o(b_byp),
    .second_bank_true_out_o(t_out), .second_bank_comp_out_o(c_out), .second_bank_pair_drv_o(drv));
  bocd_host_model i_host (.clk_sys_i(clk_sys_i), .reg_req_o(req));
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // wide enough for the whole driver bus plus both bypass flags
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ****************************************
  // watchdog and read checker
  // ****************************************
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 40000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  always @(negedge clk_sys_i) begin
    if (rvalid === 1'b1) begin
      check(rdata, i_host.exp_q.pop_front());
    end
  end
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic sig(input bit b);
    return b ? t_out[0] : a_clk;
  endfunction
  // a clock stuck low runs the bounded waits out and leaves hi at zero
  task automatic measure(input bit b);
    int n;
    n = 0;
    hi = 0;
    lo = 0;
    while (sig(b) !== 1'b0 && n < 1200) begin @(negedge clk_sys_i); n++; end
    while (sig(b) !== 1'b1 && n < 1200) begin @(negedge clk_sys_i); n++; end
    while (sig(b) === 1'b1 && hi < 600) begin @(negedge clk_sys_i); hi++; end
    while (sig(b) === 1'b0 && lo < 600) begin @(negedge clk_sys_i); lo++; end
  endtask
  task automatic set_ratio(input bit b, input logic [8:0] n);
    if (b) rb = n;
    else ra = n;
    i_host.wr(b ? 4'hd : 4'hc, n[7:0]);
    i_host.wr(4'he, {6'h00, rb[8], ra[8]});
  endtask
  task automatic defaults();
    repeat (3) @(negedge clk_sys_i);
    check({drv, a_byp, b_byp}, {{4{6'h14}}, 2'b11});
    foreach (addrs[k]) i_host.rd(addrs[k], rst[k]);
    $display("defaults done");
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (2) @(negedge clk_sys_i);
    rstn_i = 1'b1;
    defaults();
    foreach (addrs[k]) begin
      hi = $random(seed);
      i_host.wr(addrs[k], hi[7:0]);
      i_host.rd(addrs[k], hi[7:0] & i_host.used(addrs[k]));
    end
    foreach (addrs[k]) i_host.wr(addrs[k], rst[k]);
    // a write while the clock enable is low must leave the ratio untouched
    ce = 1'b0;
    i_host.wr(4'hc, 8'h55);
    ce = 1'b1;
    i_host.rd(4'hc, 8'h00);
    $display("read back done");
    i_host.wr(4'h6, 8'h10);
    for (int m = 0; m < 8; m++) begin
      i_host.wr(4'h8, {5'h02, m[2:0]});
      repeat (3) @(negedge clk_sys_i);
      check(drv[0].mode, (m == 3 || m == 7) ? 3'h0 : m[2:0]);
      check(drv[0].term_50, m == 4);
    end
    i_host.wr(4'h8, 8'h12);
    $display("modes done");
    foreach (ratios[k]) for (int b = 0; b < 2; b++) begin
      set_ratio(b[0], ratios[k]);
      repeat (4) @(negedge clk_sys_i);
      check(b ? b_byp : a_byp, ratios[k] < 2);
      measure(b[0]);
      check(hi, ratios[k] < 2 ? 0 : (ratios[k] + 1) / 2);
      if (ratios[k] > 1) check(lo, ratios[k] / 2);
    end
    $display("dividers done");
    set_ratio(1'b1, 9'h004);
    i_host.wr(4'h9, 8'h10);
    repeat (8) @(negedge clk_sys_i);
    check({drv[0].oe, drv[0].powerdown, t_out[0], c_out[0], drv[1].oe}, 5'b01001);
    sync_dis = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    check({drv[3].oe, drv[2].oe, drv[1].oe, t_out, c_out}, 11'h000);
    i_host.wr(4'h9, 8'h00);
    sync_dis = 1'b0;
    repeat (8) @(negedge clk_sys_i);
    check({drv[0].oe, drv[3].oe}, 2'b11);
    set_ratio(1'b1, 9'h000);
    div_pd = 1'b1;
    set_ratio(1'b1, 9'h004);
    repeat (3) @(negedge clk_sys_i);
    check({b_byp, t_out[0]}, 2'b10);
    div_pd = 1'b0;
    $display("disables done");
    rstn_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    rstn_i = 1'b1;
    ra = 9'h000;
    rb = 9'h000;
    defaults();
    repeat (3) @(negedge clk_sys_i);
    check(i_host.exp_q.size(), 0);
    tally_and_finish();
  end
endmodule
